//--- logic/rtcc_pkg.sv
`default_nettype none
package rtcc_pkg;
  // bus geometry
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W = 4;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_W = 8;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CONTROL = 8'h00;
  localparam logic [IDX_W-1:0] IDX_STATUS = 8'h0a;
  localparam logic [IDX_W-1:0] IDX_DEBUG = 8'h0b;
  localparam logic [IDX_W-1:0] IDX_COUNT = 8'h10;
  localparam logic [IDX_W-1:0] IDX_COMPARE = 8'h18;

  // control field positions
  localparam int unsigned CTRL_SOFT_RESET_BIT = 0;
  localparam int unsigned CTRL_ENABLE_BIT = 1;
  localparam int unsigned CTRL_MODE_LSB = 2;
  localparam int unsigned CTRL_MODE_W = 2;
  localparam int unsigned CTRL_COC_BIT = 7;
  localparam int unsigned CTRL_PRESC_LSB = 8;
  localparam int unsigned CTRL_PRESC_W = 4;
  localparam int unsigned CTRL_W = 16;
  localparam int unsigned STATUS_BUSY_BIT = 7;
  localparam int unsigned DEBUG_RUN_BIT = 0;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] COMPARE_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] COUNT_RESET = 32'h0000_0000;

  // prescaler
  localparam int unsigned PRESC_CNT_W = 10;
  localparam logic [CTRL_PRESC_W-1:0] PRESC_MAX = 4'ha;

  // synchronisation delay into the count domain
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SYNC_TIME_NS = 100;
  localparam int unsigned SYNC_CYCLES_INT = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_CNT_W = 4;
  localparam logic [SYNC_CNT_W-1:0] SYNC_LOAD = SYNC_CNT_W'(SYNC_CYCLES_INT - 1);

  typedef enum logic [1:0] {
    RTCC_WIDE_COUNTER_MODE = 2'h0,
    RTCC_NARROW_COUNTER_MODE = 2'h1,
    RTCC_CALENDAR_MODE = 2'h2,
    RTCC_RESERVED_MODE = 2'h3
  } rtcc_mode_e;

  typedef enum logic [1:0] {
    RTCC_SYNC_IDLE = 2'b00,
    RTCC_SYNC_ENABLE = 2'b01,
    RTCC_SYNC_RESET = 2'b11
  } rtcc_sync_e;

  typedef struct packed {
    logic [CTRL_PRESC_W-1:0] prescaler;
    logic clear_on_compare;
    rtcc_mode_e mode;
    logic enable;
  } rtcc_ctrl_s;

  localparam rtcc_ctrl_s CTRL_FIELDS_RESET = '{
    prescaler: 4'h0, clear_on_compare: 1'b0, mode: RTCC_WIDE_COUNTER_MODE, enable: 1'b0};
endpackage
`default_nettype wire

//--- logic/rtcc_count_core.sv
`timescale 1ns/10ps
`default_nettype none
module rtcc_count_core
  import rtcc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clear,
  input wire logic run,
  input wire logic tick,
  input wire rtcc_mode_e mode,
  input wire logic clear_on_compare,
  input wire logic [DATA_W-1:0] compare,
  output logic [DATA_W-1:0] count,
  output logic match
);
  logic narrow;
  logic hit;
  logic [DATA_W-1:0] count_inc;

  // narrow mode only looks at the low half
  assign narrow = (mode == RTCC_NARROW_COUNTER_MODE);
  assign count_inc = count + 32'h0000_0001;
  assign hit = narrow ? (count[15:0] == compare[15:0]) : (count == compare);

  // counter itself; clear-on-compare ignored in narrow mode
  always_ff @(posedge sys_clk) begin
    if (srst || clear) begin
      count <= COUNT_RESET;
    end else if (run && tick) begin
      if (narrow) begin
        count <= {16'h0000, count_inc[15:0]};
      end else if (clear_on_compare && hit) begin
        count <= COUNT_RESET;
      end else begin
        count <= count_inc;
      end
    end
  end

  // one-cycle pulse on each compare hit
  always_ff @(posedge sys_clk) begin
    if (srst || clear) begin
      match <= 1'b0;
    end else begin
      match <= run && tick && hit;
    end
  end
endmodule
`default_nettype wire

//--- logic/rtcc_top.sv
`timescale 1ns/10ps
`default_nettype none
module rtcc_top
  import rtcc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [BE_W-1:0] avs_byteenable,
  input wire logic [DATA_W-1:0] avs_writedata,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic peripheral_access_guard_lock,
  input wire logic counter_source_clock,
  input wire logic debug_halt,
  output logic [DATA_W-1:0] count_value,
  output logic compare_match,
  output logic divided_count_clock
);
  // lane merge used by the compare register and the soft reset decode
  function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old_val,
                                                   input logic [DATA_W-1:0] new_val,
                                                   input logic [BE_W-1:0] be);
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int i = 0; i < BE_W; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // mask of low prescaler bits; reserved codes saturate at the top divide
  function automatic logic [PRESC_CNT_W-1:0] presc_mask(input logic [CTRL_PRESC_W-1:0] p);
    logic [CTRL_PRESC_W-1:0] q;
    logic [PRESC_CNT_W:0] one_hot;
    q = (p > PRESC_MAX) ? PRESC_MAX : p;
    one_hot = (PRESC_CNT_W+1)'(1) << q;
    return PRESC_CNT_W'(one_hot - (PRESC_CNT_W+1)'(1));
  endfunction

  rtcc_ctrl_s ctrl;
  rtcc_sync_e sync_state;
  logic [SYNC_CNT_W-1:0] sync_cnt;
  logic enable_applied;
  logic soft_reset_pending;
  logic soft_clear;
  logic debug_run;
  logic [DATA_W-1:0] compare_reg;
  logic ack;
  logic req;
  logic take;
  logic [IDX_W-1:0] idx;
  logic [DATA_W-1:0] wdata_merged;
  logic ctrl_wr;
  logic compare_wr;
  logic debug_wr;
  logic soft_reset_req;
  logic enable_wr;
  logic sync_done;
  logic src_s1;
  logic src_s2;
  logic src_s3;
  logic src_level;
  logic src_rise;
  logic [PRESC_CNT_W-1:0] presc_cnt;
  logic presc_tick;
  logic [CTRL_W-1:0] ctrl_read;
  logic coc_read;
  logic counter_run;
  logic [DATA_W-1:0] core_count;
  logic core_match;
  logic sync_busy_flag;

  // bus slave: one wait cycle, then the taking edge
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !ack;
  assign take = req && ack;
  assign idx = avs_address[IDX_LSB +: IDX_W];
  assign wdata_merged = merge_lanes(32'h0000_0000, avs_writedata, avs_byteenable);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ack <= 1'b0;
    end else begin
      ack <= req && !ack;
    end
  end

  // write decode; control and compare sit behind the guard
  assign ctrl_wr = take && avs_write && (idx == IDX_CONTROL) &&
                   !peripheral_access_guard_lock && (avs_byteenable[1:0] != 2'b00);
  assign compare_wr = take && avs_write && (idx == IDX_COMPARE) &&
                      !peripheral_access_guard_lock;
  assign debug_wr = take && avs_write && (idx == IDX_DEBUG) && avs_byteenable[0];
  // only a one in an enabled reset lane starts a soft reset; idle lanes merge as zero
  assign soft_reset_req = ctrl_wr && wdata_merged[CTRL_SOFT_RESET_BIT];
  // enable lane written without a reset in the same access
  assign enable_wr = ctrl_wr && avs_byteenable[0] && !soft_reset_req &&
                     (sync_state != RTCC_SYNC_RESET);
  assign sync_done = (sync_state != RTCC_SYNC_IDLE) && (sync_cnt == '0);
  assign soft_clear = sync_done && (sync_state == RTCC_SYNC_RESET);

  // control fields; reset write takes precedence and discards the rest
  always_ff @(posedge sys_clk) begin
    if (srst || soft_clear) begin
      ctrl <= CTRL_FIELDS_RESET;
    end else if (ctrl_wr && !soft_reset_req && (sync_state != RTCC_SYNC_RESET)) begin
      if (avs_byteenable[1]) begin
        ctrl.prescaler <= avs_writedata[CTRL_PRESC_LSB +: CTRL_PRESC_W];
      end
      if (avs_byteenable[0]) begin
        ctrl.mode <= rtcc_mode_e'(avs_writedata[CTRL_MODE_LSB +: CTRL_MODE_W]);
        ctrl.enable <= avs_writedata[CTRL_ENABLE_BIT];
        if (!ctrl.enable) begin
          ctrl.clear_on_compare <= avs_writedata[CTRL_COC_BIT];
        end
      end
    end
  end

  // synchroniser model: enable and reset land after a fixed delay
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync_state <= RTCC_SYNC_IDLE;
      sync_cnt <= '0;
    end else if (soft_reset_req) begin
      sync_state <= RTCC_SYNC_RESET;
      sync_cnt <= SYNC_LOAD;
    end else if (enable_wr) begin
      // a new write restarts the transfer, so busy is never lost
      sync_state <= RTCC_SYNC_ENABLE;
      sync_cnt <= SYNC_LOAD;
    end else begin
      case (sync_state)
        RTCC_SYNC_ENABLE, RTCC_SYNC_RESET: begin
          if (sync_done) begin
            sync_state <= RTCC_SYNC_IDLE;
          end else begin
            sync_cnt <= sync_cnt - SYNC_CNT_W'(1);
          end
        end
        RTCC_SYNC_IDLE: begin
          sync_cnt <= '0;
        end
        default: begin
          // unused code, never reached on the usual path
          sync_state <= RTCC_SYNC_IDLE;
          sync_cnt <= '0;
        end
      endcase
    end
  end

  // applied enable only moves when the transfer completes
  always_ff @(posedge sys_clk) begin
    if (srst || soft_clear) begin
      enable_applied <= 1'b0;
    end else if (sync_done && (sync_state == RTCC_SYNC_ENABLE) && !enable_wr) begin
      enable_applied <= ctrl.enable;
    end
  end

  // reset bit reads one until the synchronised reset is over
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      soft_reset_pending <= 1'b0;
    end else if (soft_reset_req) begin
      soft_reset_pending <= 1'b1;
    end else if (soft_clear) begin
      soft_reset_pending <= 1'b0;
    end
  end
  assign sync_busy_flag = (sync_state != RTCC_SYNC_IDLE);

  // compare value, written lane by lane
  always_ff @(posedge sys_clk) begin
    if (srst || soft_clear) begin
      compare_reg <= COMPARE_RESET;
    end else if (compare_wr) begin
      compare_reg <= merge_lanes(compare_reg, avs_writedata, avs_byteenable);
    end
  end

  // debug control survives a soft reset by design
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      debug_run <= 1'b0;
    end else if (debug_wr) begin
      debug_run <= avs_writedata[DEBUG_RUN_BIT];
    end
  end

  // source clock is a pin: three stages, edge once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      src_s1 <= 1'b0;
      src_s2 <= 1'b0;
      src_s3 <= 1'b0;
      src_level <= 1'b0;
    end else begin
      src_s1 <= counter_source_clock;
      src_s2 <= src_s1;
      src_s3 <= src_s2;
      if ((src_s2 == src_s3) && (src_s3 != src_level)) begin
        src_level <= src_s3;
      end
    end
  end
  assign src_rise = (src_s2 == src_s3) && src_s3 && !src_level;

  // prescaler: source rate must stay well under a quarter of sys_clk
  always_ff @(posedge sys_clk) begin
    if (srst || soft_clear || !counter_run) begin
      presc_cnt <= '0;
    end else if (src_rise) begin
      presc_cnt <= presc_cnt + PRESC_CNT_W'(1);
    end
  end
  assign presc_tick = src_rise &&
                      ((presc_cnt & presc_mask(ctrl.prescaler)) ==
                       presc_mask(ctrl.prescaler));

  // divided clock as a registered one-cycle strobe
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      divided_count_clock <= 1'b0;
    end else begin
      divided_count_clock <= presc_tick && counter_run;
    end
  end

  // halted by debug unless told to keep running
  assign counter_run = enable_applied && (!debug_halt || debug_run);

  rtcc_count_core u_core (
    .sys_clk(sys_clk),
    .srst(srst),
    .clear(soft_clear),
    .run(counter_run),
    .tick(presc_tick),
    .mode(ctrl.mode),
    .clear_on_compare(ctrl.clear_on_compare),
    .compare(compare_reg),
    .count(core_count),
    .match(core_match)
  );
  assign count_value = core_count;
  assign compare_match = core_match;

  // control read image; reserved bits forced low
  assign coc_read = (ctrl.mode == RTCC_NARROW_COUNTER_MODE) ? 1'b0 :
                    ctrl.clear_on_compare;
  always_comb begin
    ctrl_read = CTRL_RESET;
    ctrl_read[CTRL_PRESC_LSB +: CTRL_PRESC_W] = ctrl.prescaler;
    ctrl_read[CTRL_COC_BIT] = coc_read;
    ctrl_read[CTRL_MODE_LSB +: CTRL_MODE_W] = ctrl.mode;
    ctrl_read[CTRL_ENABLE_BIT] = ctrl.enable;
    ctrl_read[CTRL_SOFT_RESET_BIT] = soft_reset_pending;
  end

  // read data captured in the wait cycle, held afterwards
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      avs_readdata <= '0;
    end else if (avs_read && !ack) begin
      case (idx)
        IDX_CONTROL: avs_readdata <= {16'h0000, ctrl_read};
        IDX_STATUS: avs_readdata <= {24'h00_0000, sync_busy_flag, 7'h00};
        IDX_DEBUG: avs_readdata <= {31'h0000_0000, debug_run};
        IDX_COUNT: avs_readdata <= core_count;
        IDX_COMPARE: avs_readdata <= compare_reg;
        default: avs_readdata <= '0;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- tb/rtcc_properties.sv
`timescale 1ns/10ps
`default_nettype none
module rtcc_properties
  import rtcc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [DATA_W-1:0] count_value,
  input wire logic compare_match,
  input wire logic divided_count_clock
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // bus answer: one wait cycle per request, none when idle
  a_wait_first: assert property (($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest)
    else $error("request start without wait cycle");
  a_wait_once: assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait cycle");
  a_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait raised while idle");
  // read data hold until the next read captures
  a_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  // outputs quiet at reset release
  a_reset_quiet: assert property ($fell(srst) |-> count_value == 32'h0 && !compare_match)
    else $error("outputs not cleared by reset");
  // source levels last several cycles, so strobes are spaced
  a_tick_gap: assert property (divided_count_clock |=> !divided_count_clock [*4])
    else $error("count strobes too close");
  a_match_gap: assert property (compare_match |=> !compare_match [*4])
    else $error("match pulses too close");
  // the counter only steps by one or clears
  a_count_step: assert property ($changed(count_value) |->
    (count_value == $past(count_value) + 32'h1) || (count_value == 32'h0))
    else $error("counter jumped");

  c_read: cover property (avs_read && !avs_waitrequest);
  c_write: cover property (avs_write && !avs_waitrequest);
  c_tick: cover property (divided_count_clock);
  c_match: cover property (compare_match);
endmodule
bind rtcc_top rtcc_properties u_rtcc_properties (.sys_clk, .srst, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .count_value, .compare_match, .divided_count_clock);
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import rtcc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [BE_W-1:0] avs_byteenable = '0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic peripheral_access_guard_lock = 1'b0;
  logic counter_source_clock = 1'b0;
  logic debug_halt = 1'b0;
  logic [DATA_W-1:0] count_value;
  logic compare_match;
  logic divided_count_clock;
  int num_errors = 0;
  int samples_checked = 0;
  localparam logic [9:0] A_CTL = 10'h000;
  localparam logic [9:0] A_STA = 10'h028;
  localparam logic [9:0] A_DBG = 10'h02c;
  localparam logic [9:0] A_CNT = 10'h040;
  localparam logic [9:0] A_CMP = 10'h060;
  // count cases: prescaler, clear-on-compare, expected count after 8 edges
  logic [3:0] tp [3] = '{4'h0, 4'h0, 4'h1};
  logic tc [3] = '{1'b1, 1'b0, 1'b0};
  logic [31:0] te [3] = '{32'h0, 32'h8, 32'h4};
  // strobes and match pulses expected over the same 8 edges
  int tk [3] = '{8, 8, 4};
  int tm [3] = '{2, 1, 1};
  int ticks_seen = 0;
  int matches_seen = 0;

  always #10 sys_clk = ~sys_clk;

  // pulse counters sampled mid-cycle, where the registered strobes are settled
  always @(negedge sys_clk) begin
    if (divided_count_clock === 1'b1) ticks_seen++;
    if (compare_match === 1'b1) matches_seen++;
  end

  rtcc_top u_rtcc_top (.sys_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_byteenable,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .peripheral_access_guard_lock,
    .counter_source_clock, .debug_halt, .count_value, .compare_match, .divided_count_clock);

  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one edge first so a new request never lands in the drop time step
  task automatic bus(input logic w, input logic [9:0] a, input logic [3:0] be,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_byteenable <= be;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    check(avs_waitrequest, 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, be, d, q);
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 4'hf, 32'h0, q);
    check(q, e);
  endtask

  // bounded poll of the busy flag; it must clear within 20 polls
  task automatic wait_sync();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      bus(1'b0, A_STA, 4'hf, 32'h0, q);
      n++;
    end while (q[7] !== 1'b0 && n < 20);
    check(q, 32'h0);
  endtask

  // levels held 4 cycles, above the three-flop sampling need
  task automatic src_edges(input int k);
    repeat (k) begin
      counter_source_clock <= 1'b1;
      repeat (4) @(posedge sys_clk);
      counter_source_clock <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic t_reset();
    rd(A_CTL, 32'h0);
    rd(A_STA, 32'h0);
    rd(A_CNT, 32'h0);
    wr(10'h3fc, 4'hf, 32'hffffffff);
    rd(10'h3fc, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_lanes();
    logic [31:0] e;
    e = 32'h0;
    for (int i = 0; i < 4; i++) begin
      wr(A_CMP, 4'h1 << i, 32'hffffffff);
      e = e | (32'hff << (8 * i));
      rd(A_CMP, e);
    end
    wr(A_CMP, 4'hc, 32'h12345678);
    rd(A_CMP, 32'h1234ffff);
    peripheral_access_guard_lock <= 1'b1;
    wr(A_CMP, 4'hf, 32'h0);
    wr(A_CTL, 4'h2, 32'h0500);
    rd(A_CMP, 32'h1234ffff);
    rd(A_CTL, 32'h0);
    peripheral_access_guard_lock <= 1'b0;
    wr(A_CMP, 4'hf, 32'h0);
    $display("test lanes done");
  endtask

  task automatic t_fields();
    logic [31:0] e;
    wr(A_CTL, 4'h2, 32'h0a00);
    rd(A_STA, 32'h0);
    rd(A_CTL, 32'h0a00);
    // bit 7 is reserved in narrow mode, so it is written as zero there
    for (int m = 0; m < 4; m++) begin
      e = 32'h0a00 | (m << 2) | ((m == 1) ? 32'h0 : 32'h80);
      wr(A_CTL, 4'h1, e);
      rd(A_CTL, e);
      wait_sync();
    end
    // enabled wide with clear-on-compare kept, then narrow mode hides it
    wr(A_CTL, 4'h1, 32'h82);
    wait_sync();
    wr(A_CTL, 4'h1, 32'h06);
    rd(A_CTL, 32'h0a06);
    wait_sync();
    wr(A_CTL, 4'h1, 32'h02);
    rd(A_CTL, 32'h0a82);
    wait_sync();
    wr(A_CTL, 4'h3, 32'h0);
    rd(A_CTL, 32'h80);
    wait_sync();
    wr(A_CTL, 4'h3, 32'h0);
    rd(A_CTL, 32'h0);
    wait_sync();
    $display("test fields done");
  endtask

  task automatic t_count();
    logic [31:0] c;
    int t0;
    int m0;
    wr(A_DBG, 4'h1, 32'h1);
    for (int i = 0; i < 3; i++) begin
      c = {20'h0, tp[i], tc[i], 7'h0};
      wr(A_CMP, 4'hf, 32'h3);
      wr(A_CTL, 4'h3, c);
      wait_sync();
      wr(A_CTL, 4'h3, c | 32'h2);
      rd(A_CTL, c | 32'h2);
      rd(A_STA, 32'h80);
      wait_sync();
      wr(A_CTL, 4'h1, (c ^ 32'h80) | 32'h2);
      rd(A_CTL, c | 32'h2);
      wait_sync();
      t0 = ticks_seen;
      m0 = matches_seen;
      src_edges(8);
      rd(A_CNT, te[i]);
      check(count_value, te[i]);
      check(ticks_seen - t0, tk[i]);
      check(matches_seen - m0, tm[i]);
      // fields stay as they were until the reset lands; only the reset bit shows
      wr(A_CTL, 4'h3, 32'h0507);
      rd(A_CTL, c | 32'h3);
      rd(A_STA, 32'h80);
      wait_sync();
      rd(A_CTL, 32'h0);
      rd(A_CNT, 32'h0);
      rd(A_CMP, 32'h0);
    end
    rd(A_DBG, 32'h1);
    // debug halt freezes the count unless the keep-running bit is set
    wr(A_DBG, 4'h1, 32'h0);
    debug_halt <= 1'b1;
    wr(A_CTL, 4'h3, 32'h2);
    wait_sync();
    src_edges(2);
    rd(A_CNT, 32'h0);
    debug_halt <= 1'b0;
    src_edges(2);
    rd(A_CNT, 32'h2);
    wr(A_CTL, 4'h1, 32'h1);
    wait_sync();
    $display("test count done");
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_lanes();
    t_fields();
    t_count();
    final_report();
  end

  // watchdog well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    final_report();
  end
endmodule
`default_nettype wire
